// [verilog/pxv_regs.vh]
`ifndef PXV_REGS_VH
`define PXV_REGS_VH
// paged register address space (4-bit PHY register address)
`define PXV_PAGED_BIT      3
`define PXV_PAGE_ID        3'h1
`define PXV_PAGE_VENDOR    3'h7
// identification page offsets
`define PXV_ADDR_CONFORM   4'h8
`define PXV_ADDR_OUI_HI    4'ha
`define PXV_ADDR_OUI_MID   4'hb
`define PXV_ADDR_OUI_LO    4'hc
`define PXV_ADDR_PART_HI   4'hd
`define PXV_ADDR_PART_MID  4'he
`define PXV_ADDR_PART_LO   4'hf
// vendor page offsets
`define PXV_ADDR_VCTRL     4'h8
`define PXV_ADDR_TEST_LO   4'h9
// base register 4 holds the power class in its low bits
`define PXV_ADDR_BASE4     4'h4
`define PXV_PWR_LSB        0
// vendor control field layout
`define PXV_NPH_BIT        7
`define PXV_SPD_MSB        1
`define PXV_SPD_LSB        0
// values
`define PXV_CONFORM_VAL    8'h01
`define PXV_OUI_VAL        24'h5a_a5_3c // arbitrary value
`define PXV_PART_VAL       24'h12_34_56 // arbitrary value
`define PXV_NPH_RST        1'b0
`define PXV_PWR_RST        3'h0
`define PXV_PEER_S400      3'h2
`define PXV_PAGE_DEPTH     8
`define PXV_PKT_NULL_BITS  16'h0000
`define PXV_SPD_RST        2'h2
`define PXV_SPD_S100       2'h0
`define PXV_SPD_S200       2'h1
`define PXV_SPD_S400       2'h2
`define PXV_SPD_ILLEGAL    2'h3
`define PXV_PKT_ACK_BITS   16'h0008
`endif

// [verilog/pxv_page_regs.v]
// Summary of operation
// - paged half selected by page select, page 1
// - conformance level reads 01h
// - maker oui across three bytes, msb 1010b
// - part code across three bytes, msb 1101b
// - page select seven exposes vendor page
// - hold set: only long packets clear requests
// - hold clear: any non-ack packet clears requests
// - null packet hold zero at hardware reset
// - speed field codes S100, S200, S400, illegal
// - speed field copied into self-id speed
// - peers always told S400 capability
// - speed field S400 at hardware reset only
// - straps give default self-id power class
// - straps loaded in the first cycle after reset, register 4 overrides
// - power class codes carried unchanged
// - vendor addresses 1001-1111 test only
`timescale 1ns/1ps
`default_nettype none
`include "pxv_regs.vh"
module pxv_page_regs (
  input  wire        mclk_i,
  input  wire        rst_n_i,
  input  wire [2:0]  page_sel_i,
  input  wire        reg_rd_i,
  input  wire        reg_wr_i,
  input  wire [3:0]  reg_addr_i,
  input  wire [7:0]  reg_wdata_i,
  input  wire [2:0]  power_category_straps_i,
  input  wire        pkt_end_i,
  input  wire [15:0] pkt_bits_i,
  input  wire        bus_reset_i,
  output reg  [7:0]  reg_rdata_o,
  output reg         reg_rvalid_o,
  output reg         null_packet_hold_o,
  output reg  [1:0]  selfid_speed_o,
  output reg  [2:0]  peer_speed_o,
  output reg         speed_illegal_o,
  output reg  [2:0]  selfid_power_o,
  output reg         clear_requests_o
);

  // decode of a register address under the current page
  function is_page;
    input [2:0] sel;
    input [2:0] want;
    input [3:0] addr;
    begin
      is_page = (sel == want) && addr[`PXV_PAGED_BIT];
    end
  endfunction

  // fixed identification values; the codes themselves are arbitrary
  localparam [23:0] maker_oui  = `PXV_OUI_VAL;    // arbitrary value
  localparam [23:0] part_code  = `PXV_PART_VAL;   // arbitrary value
  localparam        page_depth = `PXV_PAGE_DEPTH; // bytes in one paged half

  // power class source, one-hot
  localparam [2:0]  pwr_st_strap = 3'b001; // straps not yet captured
  localparam [2:0]  pwr_st_pins  = 3'b010; // strapped class in use
  localparam [2:0]  pwr_st_host  = 3'b100; // controller has overridden

  // received packet classes by data bit count, one-hot
  localparam [3:0]  pkt_null      = 4'b0001; // no data bits
  localparam [3:0]  pkt_malformed = 4'b0010; // fewer bits than an ack
  localparam [3:0]  pkt_ack       = 4'b0100; // exactly an ack
  localparam [3:0]  pkt_long      = 4'b1000; // longer than an ack

  // byte held at one identification page index; gaps read zero
  // index 0 maps to paged address 1000b, index 7 to 1111b
  function [7:0] id_byte;
    input integer idx;
    reg   [3:0]   addr;
    begin
      addr = {1'b1, idx[2:0]};
      case (addr)
        `PXV_ADDR_CONFORM:  id_byte = `PXV_CONFORM_VAL;
        `PXV_ADDR_OUI_HI:   id_byte = maker_oui[23:16];
        `PXV_ADDR_OUI_MID:  id_byte = maker_oui[15:8];
        `PXV_ADDR_OUI_LO:   id_byte = maker_oui[7:0];
        `PXV_ADDR_PART_HI:  id_byte = part_code[23:16];
        `PXV_ADDR_PART_MID: id_byte = part_code[15:8];
        `PXV_ADDR_PART_LO:  id_byte = part_code[7:0];
        default:            id_byte = 8'h00;
      endcase
    end
  endfunction

  // vendor control byte as the controller reads it
  function [7:0] vctrl_byte;
    input       hold;
    input [1:0] speed;
    begin
      vctrl_byte                            = 8'h00; // reserved bits read zero
      vctrl_byte[`PXV_NPH_BIT]              = hold;
      vctrl_byte[`PXV_SPD_MSB:`PXV_SPD_LSB] = speed;
    end
  endfunction

  // sort a received packet by its data bit count
  function [3:0] pkt_class;
    input [15:0] bits;
    begin
      if (bits == `PXV_PKT_NULL_BITS)
        pkt_class = pkt_null;
      else if (bits < `PXV_PKT_ACK_BITS)
        pkt_class = pkt_malformed;
      else if (bits == `PXV_PKT_ACK_BITS)
        pkt_class = pkt_ack;
      else
        pkt_class = pkt_long;
    end
  endfunction

  // does a packet release pending fair and priority requests
  // hold set: only long packets do; hold clear: all but an ack do
  function clears_requests;
    input        hold;
    input [15:0] bits;
    begin
      case (pkt_class(bits))
        pkt_long:      clears_requests = 1'b1;
        pkt_ack:       clears_requests = 1'b0;
        pkt_null:      clears_requests = !hold;
        pkt_malformed: clears_requests = !hold;
        default:       clears_requests = 1'b0;
      endcase
    end
  endfunction

  // speed code with no meaning on the bus
  function speed_bad;
    input [1:0] speed;
    begin
      case (speed)
        `PXV_SPD_S100: speed_bad = 1'b0;
        `PXV_SPD_S200: speed_bad = 1'b0;
        `PXV_SPD_S400: speed_bad = 1'b0;
        default:       speed_bad = 1'b1; // code 11
      endcase
    end
  endfunction

  // index of a paged register within its eight-byte table
  function [2:0] page_index;
    input [3:0] addr;
    begin
      page_index = addr[2:0];
    end
  endfunction

  // state registers, next values and decode nets
  reg        null_packet_hold_r;
  reg        null_packet_hold_nxt;
  reg [1:0]  link_speed_r;
  reg [1:0]  link_speed_nxt;
  reg [2:0]  power_class_r;
  reg [2:0]  power_class_nxt;
  reg [2:0]  pwr_state_r;
  reg [2:0]  pwr_state_nxt;
  reg [7:0]  rdata_nxt;
  reg        clr_nxt;
  wire       wr_vctrl;
  wire       wr_base4;
  wire [7:0] id_table   [0:page_depth-1];
  wire [7:0] vend_table [0:page_depth-1];
  genvar     g;

  // both paged halves as byte tables indexed by the low address bits
  generate
    for (g = 0; g < page_depth; g = g + 1) begin : g_page_byte
      assign id_table[g] = id_byte(g);
      // only index zero of the vendor page holds live bits
      if (g == 0) begin : g_ctrl
        assign vend_table[g] = vctrl_byte(null_packet_hold_r, link_speed_r);
      end else begin : g_test
        assign vend_table[g] = 8'h00; // test-only locations
      end
    end
  endgenerate

  // only the vendor control byte and base register 4 accept writes
  assign wr_vctrl = reg_wr_i && is_page(page_sel_i, `PXV_PAGE_VENDOR, reg_addr_i)
                    && (reg_addr_i == `PXV_ADDR_VCTRL);
  assign wr_base4 = reg_wr_i && (reg_addr_i == `PXV_ADDR_BASE4);

  // vendor control next state: only a write to its own byte
  always @* begin
    null_packet_hold_nxt = null_packet_hold_r;
    link_speed_nxt       = link_speed_r;
    if (wr_vctrl) begin
      null_packet_hold_nxt = reg_wdata_i[`PXV_NPH_BIT];
      link_speed_nxt       = reg_wdata_i[`PXV_SPD_MSB:`PXV_SPD_LSB];
    end
  end

  // vendor control state, hardware reset only; bus reset ignored
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      null_packet_hold_r <= `PXV_NPH_RST;
      link_speed_r       <= `PXV_SPD_RST;
    end else begin
      null_packet_hold_r <= null_packet_hold_nxt;
      link_speed_r       <= link_speed_nxt;
    end
  end

  // power class source: straps once after reset, then register 4
  always @* begin
    pwr_state_nxt   = pwr_state_r;
    power_class_nxt = power_class_r;
    case (pwr_state_r)
      pwr_st_strap: begin
        pwr_state_nxt   = pwr_st_pins;
        power_class_nxt = power_category_straps_i;
      end
      pwr_st_pins: begin
        pwr_state_nxt   = pwr_st_pins;
      end
      pwr_st_host: begin
        pwr_state_nxt   = pwr_st_host;
      end
      default: begin
        pwr_state_nxt   = pwr_st_strap; // lost state: take the straps again
      end
    endcase
    // a controller write wins, even in the capture cycle
    if (wr_base4) begin
      pwr_state_nxt   = pwr_st_host;
      power_class_nxt = reg_wdata_i[`PXV_PWR_LSB+2:`PXV_PWR_LSB];
    end
  end

  // power class state, hardware reset only
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwr_state_r   <= pwr_st_strap;
      power_class_r <= `PXV_PWR_RST;
    end else begin
      pwr_state_r   <= pwr_state_nxt;
      power_class_r <= power_class_nxt;
    end
  end

  // read data: byte of the selected page, zero elsewhere
  always @* begin
    rdata_nxt = 8'h00;
    if (is_page(page_sel_i, `PXV_PAGE_ID, reg_addr_i)) begin
      rdata_nxt = id_table[page_index(reg_addr_i)];
    end else if (is_page(page_sel_i, `PXV_PAGE_VENDOR, reg_addr_i)) begin
      rdata_nxt = vend_table[page_index(reg_addr_i)];
    end
  end

  // request clearing on received packets
  always @* begin
    clr_nxt = 1'b0;
    if (pkt_end_i) begin
      clr_nxt = clears_requests(null_packet_hold_r, pkt_bits_i);
    end
  end

  // read answer one cycle after the request, zero when idle
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rdata_o  <= reg_rd_i ? rdata_nxt : 8'h00;
      reg_rvalid_o <= reg_rd_i;
    end
  end

  // bus_reset_i is left unused on purpose: the hold bit, speed
  // field and power class survive a bus reset and only a hardware
  // reset returns them to their defaults
  // self-id fields and control status
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      null_packet_hold_o <= `PXV_NPH_RST;
      selfid_speed_o     <= `PXV_SPD_RST;
      peer_speed_o       <= `PXV_PEER_S400;
      speed_illegal_o    <= 1'b0;
      selfid_power_o     <= `PXV_PWR_RST;
    end else begin
      null_packet_hold_o <= null_packet_hold_r;
      selfid_speed_o     <= link_speed_r;
      peer_speed_o       <= `PXV_PEER_S400;
      speed_illegal_o    <= speed_bad(link_speed_r);
      selfid_power_o     <= power_class_r;
    end
  end

  // one-cycle pulse that clears fair and priority requests
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clear_requests_o <= 1'b0;
    end else begin
      clear_requests_o <= clr_nxt;
    end
  end

endmodule // pxv_page_regs
`default_nettype wire

// [testbench/pxv_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module pxv_chk (
  input wire logic        mclk_i, rst_n_i, reg_rd_i, reg_wr_i, pkt_end_i, reg_rvalid_o,
  input wire logic        null_packet_hold_o, clear_requests_o,
  input wire logic [1:0]  selfid_speed_o,
  input wire logic [2:0]  page_sel_i, peer_speed_o, selfid_power_o,
  input wire logic [3:0]  reg_addr_i,
  input wire logic [7:0]  reg_wdata_i, reg_rdata_o,
  input wire logic [15:0] pkt_bits_i
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // read answers and fixed values
  property p_rv; reg_rd_i |=> reg_rvalid_o; endproperty
  a_rv: assert property (p_rv) else $error("read not answered");
  property p_cf; reg_rd_i && page_sel_i == 3'h1 && reg_addr_i == 4'h8 |=> reg_rdata_o == 8'h01;
  endproperty
  a_cf: assert property (p_cf) else $error("bad conformance");
  property p_pr; peer_speed_o == 3'h2; endproperty
  a_pr: assert property (p_pr) else $error("peer speed");
  // request clearing on packet end
  property p_c0; pkt_end_i && !$past(reg_wr_i) && !null_packet_hold_o
    |=> clear_requests_o == ($past(pkt_bits_i) != 16'h8); endproperty
  a_c0: assert property (p_c0) else $error("clear, hold off");
  property p_c1; pkt_end_i && !$past(reg_wr_i) && null_packet_hold_o
    |=> clear_requests_o == ($past(pkt_bits_i) > 16'h8); endproperty
  a_c1: assert property (p_c1) else $error("clear, hold on");
  property p_ci; !pkt_end_i |=> !clear_requests_o; endproperty
  a_ci: assert property (p_ci) else $error("spurious clear");
  // self-id fields follow their registers
  property p_pw; reg_wr_i && reg_addr_i == 4'h4 ##1 !reg_wr_i
    |=> selfid_power_o == $past(reg_wdata_i[2:0], 2); endproperty
  a_pw: assert property (p_pw) else $error("power class");
  property p_sp; reg_wr_i && page_sel_i == 3'h7 && reg_addr_i == 4'h8 ##1 !reg_wr_i
    |=> selfid_speed_o == $past(reg_wdata_i[1:0], 2); endproperty
  a_sp: assert property (p_sp) else $error("self-id speed");
  c_rd: cover property (reg_rd_i ##1 reg_rvalid_o);
  c_cl: cover property (clear_requests_o);
  c_ho: cover property (null_packet_hold_o && pkt_end_i);
endmodule // pxv_chk
bind pxv_page_regs pxv_chk u_chk (
  .mclk_i             (mclk_i),
  .rst_n_i            (rst_n_i),
  .reg_rd_i           (reg_rd_i),
  .reg_wr_i           (reg_wr_i),
  .pkt_end_i          (pkt_end_i),
  .reg_rvalid_o       (reg_rvalid_o),
  .null_packet_hold_o (null_packet_hold_o),
  .clear_requests_o   (clear_requests_o),
  .selfid_speed_o     (selfid_speed_o),
  .page_sel_i         (page_sel_i),
  .peer_speed_o       (peer_speed_o),
  .selfid_power_o     (selfid_power_o),
  .reg_addr_i         (reg_addr_i),
  .reg_wdata_i        (reg_wdata_i),
  .reg_rdata_o        (reg_rdata_o),
  .pkt_bits_i         (pkt_bits_i)
);
`default_nettype wire

// [testbench/pxv_llc.sv]
`timescale 1ns/1ps
`default_nettype none
module pxv_llc (
  input  wire logic       mclk_i, rst_n_i, reg_wr_i,
  input  wire logic [3:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output var  logic [2:0] page_sel_o
);
  // page select of base register 7, written by the controller
  always @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i) page_sel_o <= 3'h0;
    else if (reg_wr_i && reg_addr_i == 4'h7) page_sel_o <= reg_wdata_i[7:5];
endmodule // pxv_llc
`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pxv_regs.vh"
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin failures++; \
  $display("[FAIL] %s exp %h got %h", n, e, a); end end
module testbench;
  logic mclk_i = 0, rst_n_i = 0, rd = 0, wr = 0, pe = 0, br = 0, rv, nph, ill, clr;
  logic [3:0] ad = 0;
  logic [7:0] wd = 0, v, rdat;
  logic [15:0] pb = 0, b, bl[4] = '{16'h0, 16'h7, 16'h8, 16'h9};
  logic [2:0] st = 0, pg, peer, pwr;
  logic [1:0] sp;
  int failures = 0, cmp_count = 0, cyc = 0, i, j;
  always #50 mclk_i = ~mclk_i;
  pxv_llc llc (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_wr_i(wr), .reg_addr_i(ad),
    .reg_wdata_i(wd), .page_sel_o(pg));
  pxv_page_regs dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .page_sel_i(pg), .reg_rd_i(rd),
    .reg_wr_i(wr), .reg_addr_i(ad), .reg_wdata_i(wd), .power_category_straps_i(st),
    .pkt_end_i(pe), .pkt_bits_i(pb), .bus_reset_i(br), .reg_rdata_o(rdat), .reg_rvalid_o(rv),
    .null_packet_hold_o(nph), .selfid_speed_o(sp), .peer_speed_o(peer), .speed_illegal_o(ill),
    .selfid_power_o(pwr), .clear_requests_o(clr));
  // identification page contents
  function automatic [7:0] id_exp(input [3:0] a);
    if (a == 4'h8) return 8'h01;
    if (a == 4'h9) return 8'h00;
    if (a < 4'hd) return 8'(`PXV_OUI_VAL >> (8 * (12 - a)));
    return 8'(`PXV_PART_VAL >> (8 * (15 - a)));
  endfunction
  // one register request, idle cycle first
  task req(input w, input [3:0] a, input [7:0] d);
    @(posedge mclk_i) #1; ad = a; wd = d; wr = w; rd = !w;
    @(posedge mclk_i) #1; wr = 0; rd = 0;
  endtask
  task rdc(input [3:0] a, input [7:0] e);
    req(0, a, 8'h00);
    `CHK("rdata", e, rdat)
    `CHK("rvalid", 1'b1, rv)
  endtask
  task report_and_stop;
    if (failures == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge mclk_i) if (++cyc > 3000) begin failures++; report_and_stop; end
  initial begin
    void'($urandom(32'hd97f));
    st = $urandom;
    repeat (4) @(posedge mclk_i);
    #1 rst_n_i = 1;
    repeat (2) @(posedge mclk_i);
    #1 `CHK("power", st, pwr)
    `CHK("speed", 2'h2, sp)
    `CHK("peer", 3'h2, peer)
    req(1, 4'h7, 8'h20);
    for (i = 8; i < 16; i++) begin req(1, i[3:0], 8'hff); rdc(i[3:0], id_exp(i[3:0])); end
    req(1, 4'h7, 8'he0);
    rdc(4'h8, 8'h02);
    for (i = 9; i < 16; i++) rdc(i[3:0], 8'h00);
    for (i = 0; i < 24; i++) begin
      v = $urandom;
      if (i < 4) v[1:0] = i[1:0];
      req(1, 4'h8, v);
      br = 1;
      rdc(4'h8, v & 8'h83);
      br = 0;
      `CHK("spd", v[1:0], sp)
      `CHK("ill", &v[1:0], ill)
      `CHK("hold", v[7], nph)
      for (j = 0; j < 5; j++) begin
        b = j < 4 ? bl[j] : 16'($urandom);
        @(posedge mclk_i) #1; pe = 1; pb = b;
        @(posedge mclk_i) #1; pe = 0;
        `CHK("clear", v[7] ? b > 16'h8 : b != 16'h8, clr)
      end
    end
    for (i = 0; i < 8; i++) begin
      v = $urandom;
      v[2:0] = i[2:0];
      req(1, 4'h4, v);
      @(posedge mclk_i) #1 `CHK("pwr", v[2:0], pwr)
    end
    report_and_stop;
  end
endmodule // testbench
`default_nettype wire
